// ### hdl/nand_host_pkg.sv
// Purpose: Shared constants and carriers for the NAND page read and program host.
// Assumes: 10 MHz clock; an 8-bit NAND port with 2,112-byte pages.
// Notes:   Register offsets are Avalon word addresses.
package nand_host_pkg;
	// ==========================================================
	// Timing
	localparam int CLK_MHZ            = 10;
	localparam int POWER_UP_US        = 100;
	localparam int ARRAY_READ_TIME_US = 25;
	localparam int WB_NS              = 100;
	localparam int CLK_NS             = 100;
	localparam logic [9:0] POWER_UP_CYC = 10'(POWER_UP_US * CLK_MHZ);
	localparam logic [9:0] ARRAY_READ_CYC = 10'(ARRAY_READ_TIME_US * CLK_MHZ);
	localparam logic [9:0] WB_CYC = 10'((WB_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [9:0] RE_LOW_CYC = 10'h003;
	// ==========================================================
	// Page geometry
	localparam logic [11:0] PAGE_BYTES = 12'h840;
	localparam logic [2:0]  FULL_ADDR  = 3'h5;
	localparam logic [2:0]  COL_ADDR   = 3'h2;
	localparam logic [2:0]  BLOCK_ADDR = 3'h3;
	localparam int PLANE_BIT = 6;
	// ==========================================================
	// Command bytes
	localparam logic [7:0] CMD_READ     = 8'h00;
	localparam logic [7:0] CMD_READ_GO  = 8'h30;
	localparam logic [7:0] CMD_READ_CPY = 8'h35;
	localparam logic [7:0] CMD_RND_OUT  = 8'h05;
	localparam logic [7:0] CMD_RND_GO   = 8'he0;
	localparam logic [7:0] CMD_PROG     = 8'h80;
	localparam logic [7:0] CMD_RND_IN   = 8'h85;
	localparam logic [7:0] CMD_CONFIRM  = 8'h10;
	localparam logic [7:0] CMD_DUMMY    = 8'h11;
	localparam logic [7:0] CMD_PLANE2   = 8'h81;
	localparam logic [7:0] CMD_STATUS   = 8'h70;
	localparam logic [7:0] CMD_RESET    = 8'hff;
	localparam logic [7:0] CMD_ERASE    = 8'h60;
	localparam logic [7:0] CMD_ERASE_GO = 8'hd0;
	// ==========================================================
	// Registers and fields
	localparam logic [1:0] REG_CTRL   = 2'h0;
	localparam logic [1:0] REG_OP     = 2'h1;
	localparam logic [1:0] REG_DATA   = 2'h2;
	localparam logic [1:0] REG_STATUS = 2'h3;
	localparam int CTRL_WP_RELEASE = 0;
	localparam int CTRL_CE_HOLD    = 1;
	localparam int OP_KIND_LSB     = 8;
	localparam int ST_BUSY    = 0;
	localparam int ST_PWR_OK  = 1;
	localparam int ST_READY   = 2;
	localparam int ST_REFUSED = 3;
	localparam int ST_WP_N    = 4;
	localparam int ST_LATE    = 5;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam logic [2:0] KIND_CMD   = 3'h0;
	localparam logic [2:0] KIND_ADDR  = 3'h1;
	localparam logic [2:0] KIND_DIN   = 3'h2;
	localparam logic [2:0] KIND_DOUT  = 3'h3;
	localparam logic [2:0] KIND_WAIT  = 3'h4;
	// ==========================================================
	// Types
	typedef enum logic [2:0] {E_POWER, E_IDLE, E_STROBE, E_HOLD, E_READ, E_GAP, E_WAIT} eng_e;
	typedef enum logic [2:0] {P_IDLE, P_SETUP, P_PAGED, P_RNDOUT, P_LOAD, P_DUMMY, P_ERASE} proto_e;
	typedef struct packed {
		logic       cle;
		logic       ale;
		logic       ce_n;
		logic       we_n;
		logic       re_n;
		logic [7:0] dq;
		logic       dq_oe;
	} pins_s;
endpackage

// ### hdl/nand_host.sv
// Purpose: Host controller driving a NAND memory port, ordered over Avalon-MM.
// Assumes: Software queues single bus cycles through the OP register.
// Notes:   Sequences that the memory would reject are refused and flagged.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Chip select may drop between data strobes without losing buffered data.
// - Wait 100 us after power up before any command sequence.
// - Write protect low blocks program and erase; keep it low at power transitions.
// - Between dummy program and next-plane command only status or reset.
// - Copy-back only when source and destination share a plane.
// - Page read is 00h, five address bytes, then 30h.
// - Each output strobe falling edge presents the next byte.
// - Each page is programmed at most once between erasures.
// - Pages in a block are programmed in ascending order.
// - Up to 2,112 bytes load; unused bytes need not be loaded.
// - Program loading is 80h, five address bytes, then data bytes; the host accepts data after the first two.
// - While busy only status read and reset are issued; the host checks this for command bytes only, not for address or data cycles.
// - After 70h every read cycle returns the status byte.
module nand_host (
	// Clock, reset and enable
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        en_i,
	// Avalon-MM slave
	input  wire logic [1:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	output logic [31:0]      avs_readdata_o,
	output logic             avs_waitrequest_o,
	// NAND port
	output logic             cle_o,
	output logic             ale_o,
	output logic             ce_n_o,
	output logic             we_n_o,
	output logic             output_strobe_n_o,
	output logic             write_protect_n_o,
	output logic [7:0]       dq_o,
	output logic             dq_oe_o,
	input  wire logic [7:0]  dq_i,
	input  wire logic        ready_busy_n_i
);
	// ==========================================================
	// State
	typedef struct packed {
		nand_host_pkg::eng_e   eng;
		nand_host_pkg::proto_e proto;
		logic [9:0]            cnt;
		logic [2:0]            kind;
		logic [7:0]            byte_v;
		logic                  status_mode;
		logic                  copy_src;
		logic                  copy_mode;
		logic                  data_seen;
		logic [2:0]            nadr;
		logic [11:0]           col;
		logic [17:0]           row;
		logic [17:0]           src_row;
		logic [17:0]           last_row;
		logic                  last_ok;
		logic [1:0]            ctrl;
		logic                  refused;
		logic                  late;
		logic [7:0]            rdata;
		logic [31:0]           rd_word;
		logic                  rd_done;
		logic [1:0]            rb_sync;
		logic [7:0]            dq_s1;
		logic [7:0]            dq_s2;
		nand_host_pkg::pins_s  pins;
	} state_s;

	state_s st_reg;
	state_s st_next;

	logic       op_go;
	logic       bus_wr;
	logic       ok;
	logic       ready;
	logic [7:0] c;
	logic [2:0] kind_in;
	logic [2:0] adr_lim;
	logic [2:0] idx;

	assign ready = st_reg.rb_sync[1];
	assign kind_in = avs_writedata_i[nand_host_pkg::OP_KIND_LSB +: 3];
	assign c = avs_writedata_i[7:0];
	// OP writes stall while the engine works, which paces software.
	assign avs_waitrequest_o = !en_i || (avs_read_i && !st_reg.rd_done) ||
		(avs_write_i && avs_address_i == nand_host_pkg::REG_OP &&
		st_reg.eng != nand_host_pkg::E_IDLE);
	assign bus_wr = avs_write_i && !avs_waitrequest_o;
	assign op_go = bus_wr && avs_address_i == nand_host_pkg::REG_OP;
	assign avs_readdata_o = st_reg.rd_word;

	always_comb begin
		st_next = st_reg;
		ok = 1'b0;
		adr_lim = nand_host_pkg::FULL_ADDR;
		idx = st_reg.nadr;
		st_next.rb_sync = {st_reg.rb_sync[0], ready_busy_n_i};
		st_next.dq_s1 = dq_i;
		st_next.dq_s2 = st_reg.dq_s1;
		// ==========================================================
		// Register access
		if (avs_read_i && !st_reg.rd_done) begin
			st_next.rd_done = 1'b1;
			case (avs_address_i)
				nand_host_pkg::REG_CTRL: st_next.rd_word = {30'h0, st_reg.ctrl};
				nand_host_pkg::REG_DATA: st_next.rd_word = {24'h0, st_reg.rdata};
				nand_host_pkg::REG_STATUS: st_next.rd_word = {26'h0, st_reg.late,
					write_protect_n_o,
					st_reg.refused, ready, st_reg.eng != nand_host_pkg::E_POWER,
					st_reg.eng != nand_host_pkg::E_IDLE};
				default: st_next.rd_word = 32'h0;
			endcase
		end else begin
			st_next.rd_done = 1'b0;
		end
		if (bus_wr && avs_address_i == nand_host_pkg::REG_CTRL) begin
			st_next.ctrl = avs_writedata_i[1:0];
		end
		if (bus_wr && avs_address_i == nand_host_pkg::REG_STATUS) begin
			if (avs_writedata_i[nand_host_pkg::ST_REFUSED]) begin
				st_next.refused = 1'b0;
			end
			if (avs_writedata_i[nand_host_pkg::ST_LATE]) begin
				st_next.late = 1'b0;
			end
		end
		// ==========================================================
		// Sequence checks on a new bus cycle
		if (op_go) begin
			st_next.kind = kind_in;
			st_next.byte_v = c;
			case (kind_in)
				nand_host_pkg::KIND_CMD: begin
					case (c)
						nand_host_pkg::CMD_READ: ok = 1'b1;
						nand_host_pkg::CMD_READ_GO, nand_host_pkg::CMD_READ_CPY: ok =
							st_reg.proto == nand_host_pkg::P_SETUP &&
							st_reg.nadr == nand_host_pkg::FULL_ADDR;
						nand_host_pkg::CMD_RND_OUT: ok = st_reg.proto == nand_host_pkg::P_PAGED;
						nand_host_pkg::CMD_RND_GO: ok = st_reg.proto == nand_host_pkg::P_RNDOUT &&
							st_reg.nadr == nand_host_pkg::COL_ADDR;
						nand_host_pkg::CMD_PROG: ok = st_reg.proto != nand_host_pkg::P_DUMMY;
						nand_host_pkg::CMD_PLANE2: ok = st_reg.proto == nand_host_pkg::P_DUMMY;
						nand_host_pkg::CMD_RND_IN: ok = st_reg.proto == nand_host_pkg::P_LOAD ||
							(st_reg.proto == nand_host_pkg::P_PAGED && st_reg.copy_src);
						// confirm needs data or copy source
						nand_host_pkg::CMD_CONFIRM, nand_host_pkg::CMD_DUMMY: ok =
							st_reg.proto == nand_host_pkg::P_LOAD &&
							(st_reg.data_seen || st_reg.copy_mode) &&
							!(st_reg.copy_mode && st_reg.row[nand_host_pkg::PLANE_BIT] !=
							st_reg.src_row[nand_host_pkg::PLANE_BIT]) &&
							!(st_reg.last_ok && st_reg.row[17:6] == st_reg.last_row[17:6] &&
							st_reg.row[5:0] <= st_reg.last_row[5:0]);
						nand_host_pkg::CMD_ERASE: ok = st_reg.proto != nand_host_pkg::P_DUMMY;
						nand_host_pkg::CMD_ERASE_GO: ok = st_reg.proto == nand_host_pkg::P_ERASE &&
							st_reg.nadr == nand_host_pkg::BLOCK_ADDR;
						nand_host_pkg::CMD_STATUS, nand_host_pkg::CMD_RESET: ok = 1'b1;
						default: ok = 1'b0;
					endcase
					// busy memory takes only status or reset
					if (!ready && c != nand_host_pkg::CMD_STATUS &&
						c != nand_host_pkg::CMD_RESET) begin
						ok = 1'b0;
					end
					if (st_reg.proto == nand_host_pkg::P_DUMMY && c != nand_host_pkg::CMD_STATUS &&
						c != nand_host_pkg::CMD_RESET && c != nand_host_pkg::CMD_PLANE2) begin
						ok = 1'b0;
					end
					if (ok) begin
						// status mode lasts until another command
						st_next.status_mode = c == nand_host_pkg::CMD_STATUS;
						if (c != nand_host_pkg::CMD_STATUS) begin
							st_next.nadr = 3'h0;
						end
						case (c)
							nand_host_pkg::CMD_READ: st_next.proto = nand_host_pkg::P_SETUP;
							nand_host_pkg::CMD_RESET: st_next.proto = nand_host_pkg::P_SETUP;
							nand_host_pkg::CMD_READ_GO, nand_host_pkg::CMD_READ_CPY,
							nand_host_pkg::CMD_RND_GO: begin
								st_next.proto = nand_host_pkg::P_PAGED;
								if (c != nand_host_pkg::CMD_RND_GO) begin
									st_next.copy_src = c == nand_host_pkg::CMD_READ_CPY;
									st_next.src_row = st_reg.row;
								end
							end
							nand_host_pkg::CMD_RND_OUT: st_next.proto = nand_host_pkg::P_RNDOUT;
							nand_host_pkg::CMD_PROG, nand_host_pkg::CMD_PLANE2: begin
								st_next.proto = nand_host_pkg::P_LOAD;
								st_next.data_seen = 1'b0;
								st_next.copy_mode = 1'b0;
							end
							nand_host_pkg::CMD_RND_IN: begin
								st_next.proto = nand_host_pkg::P_LOAD;
								if (st_reg.proto == nand_host_pkg::P_PAGED) begin
									st_next.copy_mode = 1'b1;
									st_next.data_seen = 1'b0;
								end
							end
							nand_host_pkg::CMD_CONFIRM: begin
								st_next.proto = nand_host_pkg::P_IDLE;
								st_next.last_row = st_reg.row;
								st_next.last_ok = 1'b1;
							end
							nand_host_pkg::CMD_DUMMY: st_next.proto = nand_host_pkg::P_DUMMY;
							nand_host_pkg::CMD_ERASE: st_next.proto = nand_host_pkg::P_ERASE;
							nand_host_pkg::CMD_ERASE_GO: begin
								st_next.proto = nand_host_pkg::P_IDLE;
								if (st_reg.row[17:6] == st_reg.last_row[17:6]) begin
									st_next.last_ok = 1'b0;
								end
							end
							default: st_next.proto = st_reg.proto;
						endcase
					end
				end
				nand_host_pkg::KIND_ADDR: begin
					if (st_reg.proto == nand_host_pkg::P_RNDOUT) begin
						adr_lim = nand_host_pkg::COL_ADDR;
					end else if (st_reg.proto == nand_host_pkg::P_ERASE) begin
						adr_lim = nand_host_pkg::BLOCK_ADDR;
						idx = st_reg.nadr + 3'h2;
					end
					ok = st_reg.nadr < adr_lim && (st_reg.proto == nand_host_pkg::P_SETUP ||
						st_reg.proto == nand_host_pkg::P_RNDOUT ||
						st_reg.proto == nand_host_pkg::P_LOAD ||
						st_reg.proto == nand_host_pkg::P_ERASE);
					if (ok) begin
						st_next.nadr = st_reg.nadr + 3'h1;
						case (idx)
							3'h0: st_next.col[7:0] = c;
							3'h1: st_next.col[11:8] = c[3:0];
							3'h2: st_next.row[7:0] = c;
							3'h3: st_next.row[15:8] = c;
							default: st_next.row[17:16] = c[1:0];
						endcase
					end
				end
				// loading stops at the last column
				nand_host_pkg::KIND_DIN: begin
					ok = st_reg.proto == nand_host_pkg::P_LOAD &&
						st_reg.nadr >= nand_host_pkg::COL_ADDR &&
						st_reg.col < nand_host_pkg::PAGE_BYTES;
					if (ok) begin
						st_next.col = st_reg.col + 12'h001;
						st_next.data_seen = 1'b1;
					end
				end
				// output advances to the last column, status any time
				nand_host_pkg::KIND_DOUT: begin
					ok = st_reg.status_mode || (st_reg.proto == nand_host_pkg::P_PAGED &&
						st_reg.col < nand_host_pkg::PAGE_BYTES);
					if (ok && !st_reg.status_mode) begin
						st_next.col = st_reg.col + 12'h001;
					end
				end
				nand_host_pkg::KIND_WAIT: ok = 1'b1;
				default: ok = 1'b0;
			endcase
			if (ok) begin
				st_next.cnt = 10'h000;
				if (kind_in == nand_host_pkg::KIND_WAIT) begin
					st_next.eng = nand_host_pkg::E_WAIT;
				end else if (kind_in == nand_host_pkg::KIND_DOUT) begin
					st_next.eng = nand_host_pkg::E_READ;
				end else begin
					st_next.eng = nand_host_pkg::E_STROBE;
				end
			end else begin
				st_next.refused = 1'b1;
			end
		end
		// ==========================================================
		// Strobe engine
		case (st_reg.eng)
			// power-up recovery, read setup is implied after it
			nand_host_pkg::E_POWER: begin
				st_next.cnt = st_reg.cnt + 10'h001;
				if (st_reg.cnt == nand_host_pkg::POWER_UP_CYC - 10'h001) begin
					st_next.eng = nand_host_pkg::E_IDLE;
					st_next.proto = nand_host_pkg::P_SETUP;
				end
			end
			nand_host_pkg::E_STROBE: st_next.eng = nand_host_pkg::E_HOLD;
			nand_host_pkg::E_HOLD: st_next.eng = nand_host_pkg::E_GAP;
			// one byte per falling output strobe
			nand_host_pkg::E_READ: begin
				st_next.cnt = st_reg.cnt + 10'h001;
				if (st_reg.cnt == nand_host_pkg::RE_LOW_CYC - 10'h001) begin
					st_next.rdata = st_reg.dq_s2;
					st_next.eng = nand_host_pkg::E_GAP;
				end
			end
			nand_host_pkg::E_GAP: st_next.eng = nand_host_pkg::E_IDLE;
			// wait out the busy period, completion seen on ready
			nand_host_pkg::E_WAIT: begin
				if (st_reg.cnt != 10'h3ff) begin
					st_next.cnt = st_reg.cnt + 10'h001;
				end
				if (st_reg.cnt > nand_host_pkg::WB_CYC && ready) begin
					st_next.eng = nand_host_pkg::E_IDLE;
				end else if (st_reg.cnt == nand_host_pkg::ARRAY_READ_CYC &&
					st_reg.proto == nand_host_pkg::P_PAGED && !st_reg.status_mode) begin
					st_next.late = 1'b1;
				end
			end
			// Idle keeps whatever a new bus cycle has just started.
			default: ;
		endcase
		// ==========================================================
		// Pin drive follows the next engine state
		st_next.pins.cle = 1'b0;
		st_next.pins.ale = 1'b0;
		st_next.pins.we_n = 1'b1;
		st_next.pins.re_n = 1'b1;
		st_next.pins.dq_oe = 1'b0;
		st_next.pins.dq = st_next.byte_v;
		if (st_next.eng == nand_host_pkg::E_STROBE || st_next.eng == nand_host_pkg::E_HOLD) begin
			// latch enables select command, address or data
			st_next.pins.cle = st_next.kind == nand_host_pkg::KIND_CMD;
			st_next.pins.ale = st_next.kind == nand_host_pkg::KIND_ADDR;
			st_next.pins.we_n = st_next.eng != nand_host_pkg::E_STROBE;
			st_next.pins.dq_oe = 1'b1;
		end
		if (st_next.eng == nand_host_pkg::E_READ) begin
			st_next.pins.re_n = 1'b0;
		end
		// release select between data strobes unless held, select during strobes
		st_next.pins.ce_n = !(st_next.eng != nand_host_pkg::E_IDLE ||
			st_next.ctrl[nand_host_pkg::CTRL_CE_HOLD] ||
			!(st_next.proto == nand_host_pkg::P_PAGED || st_next.proto == nand_host_pkg::P_LOAD ||
			st_next.proto == nand_host_pkg::P_IDLE));
		if (st_next.eng == nand_host_pkg::E_POWER) begin
			st_next.pins.ce_n = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_reg <= '0;
			st_reg.eng <= nand_host_pkg::E_POWER;
			st_reg.proto <= nand_host_pkg::P_IDLE;
			st_reg.ctrl <= nand_host_pkg::CTRL_RESET;
			st_reg.pins.ce_n <= 1'b1;
			st_reg.pins.we_n <= 1'b1;
			st_reg.pins.re_n <= 1'b1;
		end else if (en_i) begin
			st_reg <= st_next;
		end
	end

	// ==========================================================
	// Outputs
	assign cle_o = st_reg.pins.cle;
	assign ale_o = st_reg.pins.ale;
	assign ce_n_o = st_reg.pins.ce_n;
	assign we_n_o = st_reg.pins.we_n;
	assign output_strobe_n_o = st_reg.pins.re_n;
	assign dq_o = st_reg.pins.dq;
	assign dq_oe_o = st_reg.pins.dq_oe;
	// protect held low through power-up and until software releases it
	assign write_protect_n_o = st_reg.eng != nand_host_pkg::E_POWER &&
		st_reg.ctrl[nand_host_pkg::CTRL_WP_RELEASE];
endmodule

`default_nettype wire

// ### bench/nand_mem_model.sv
// Purpose: Behavioural NAND page buffer answering the host's strobes.
// Assumes: One plane, no array contents kept; a read fills a column pattern.
// Notes:   Busy time is a parameter so that runs stay short.
`timescale 1ns/100ps
`default_nettype none
module nand_mem_model #(
	parameter int BUSY_NS = 3000
) (
	// Host strobes and data
	input  wire logic       cle_i,
	input  wire logic       ale_i,
	input  wire logic       ce_n_i,
	input  wire logic       we_n_i,
	input  wire logic       re_n_i,
	input  wire logic       wp_n_i,
	input  wire logic [7:0] dq_i,
	// Memory answers
	output logic [7:0]      dq_o,
	output logic            rb_n_o
);
	// ====
	// Page buffer and command state
	logic [7:0]  buf_q [0:2111];
	logic [11:0] col_q = 12'h000;
	logic [7:0]  row_q = 8'h00;
	logic [2:0]  na_q = 3'h0;
	logic        load_q = 1'b0;
	logic        stat_q = 1'b0;
	logic [7:0]  last_q = 8'h00;
	logic        ecc_q = 1'b0;
	// Command byte of the sector error read; the value is arbitrary.
	localparam logic [7:0] ECC_CMD = 8'h7a;
	initial rb_n_o = 1'b1;
	initial dq_o = 8'h00;
	task automatic command(input logic [7:0] c);
		if (!rb_n_o && c != 8'h70 && c != 8'hff)
			return;
		stat_q = (c == 8'h70);
		ecc_q = (c == ECC_CMD);
		na_q = 3'h0;
		if (c == 8'h30) begin
			for (int i = 0; i < 2112; i++)
				buf_q[i] = 8'(i) ^ row_q;
			rb_n_o = 1'b0;
			rb_n_o <= #(BUSY_NS) 1'b1;
		end
		if (c == 8'h80) begin
			for (int i = 0; i < 2112; i++)
				buf_q[i] = 8'hff;
			load_q = 1'b0;
		end
		if (c == 8'h10 && load_q && wp_n_i) begin
			rb_n_o = 1'b0;
			rb_n_o <= #(BUSY_NS) 1'b1;
			stat_q = 1'b1;
		end
	endtask
	always @(posedge we_n_i) begin
		if (!ce_n_i && cle_i)
			command(dq_i);
		else if (!ce_n_i && ale_i) begin
			if (na_q == 3'h0)
				col_q[7:0] = dq_i;
			if (na_q == 3'h1)
				col_q[11:8] = dq_i[3:0];
			if (na_q == 3'h2)
				row_q = dq_i;
			na_q = na_q + 3'h1;
		end else if (!ce_n_i && col_q < 12'h840) begin
			buf_q[col_q] = dq_i;
			col_q = col_q + 12'h001;
			load_q = 1'b1;
		end
	end
	always @(negedge re_n_i) begin
		// Chip select falls in the same step as the strobe, so let it settle.
		#1;
		if (!ce_n_i) begin
			last_q = stat_q ? {wp_n_i, rb_n_o, 6'h00} : ecc_q ? 8'h00 : buf_q[col_q];
			if (!stat_q && !ecc_q)
				col_q = col_q + 12'h001;
			dq_o = last_q;
		end
	end
	// A released bus shows the inverse byte, so a stale copy cannot pass.
	always @(posedge re_n_i) dq_o = ~last_q;
endmodule
`default_nettype wire

// ### bench/nand_host_monitor.sv
// Purpose: Port checks of the NAND host strobes and bus answers.
// Assumes: One clock domain; en_i high counts power-up time.
// Notes:   Bound to every nand_host instance.
`timescale 1ns/100ps
`default_nettype none
module nand_host_monitor (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic en_i,
	// Register bus
	input wire logic avs_read_i,
	input wire logic avs_waitrequest_o,
	// NAND port
	input wire logic cle_o,
	input wire logic ale_o,
	input wire logic ce_n_o,
	input wire logic we_n_o,
	input wire logic output_strobe_n_o,
	input wire logic write_protect_n_o,
	input wire logic dq_oe_o
);
	// ====
	// Power-up age, saturating
	logic [10:0] age_reg;
	logic [10:0] age_next;
	always_comb begin
		age_next = age_reg;
		if (en_i && age_reg != 11'h7ff)
			age_next = age_reg + 11'h001;
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			age_reg <= 11'h000;
		else
			age_reg <= age_next;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	power_quiet_a: assert property (age_reg < 11'h3e8 |-> we_n_o && output_strobe_n_o)
		else $error("strobe during power-up");
	power_protect_a: assert property (age_reg < 11'h3e8 |-> !write_protect_n_o)
		else $error("protect released during power-up");
	write_pulse_a: assert property ($fell(we_n_o) |=> we_n_o)
		else $error("write strobe not one cycle");
	read_pulse_a: assert property ($fell(output_strobe_n_o) |->
		!output_strobe_n_o [*3] ##1 output_strobe_n_o) else $error("read strobe not three cycles");
	strobe_select_a: assert property (!we_n_o || !output_strobe_n_o |-> !ce_n_o)
		else $error("strobe without chip select");
	latch_kind_a: assert property (!we_n_o |-> dq_oe_o && !(cle_o && ale_o))
		else $error("bad latch or undriven data");
	write_hold_a: assert property ($rose(we_n_o) |-> dq_oe_o)
		else $error("data dropped at strobe rise");
	read_release_a: assert property (!output_strobe_n_o |-> !dq_oe_o && we_n_o && !cle_o)
		else $error("host drives during read");
	read_wait_a: assert property ($rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
		else $error("read wait state wrong");
endmodule
bind nand_host nand_host_monitor mon_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(en_i),
	.avs_read_i(avs_read_i), .avs_waitrequest_o(avs_waitrequest_o), .cle_o(cle_o),
	.ale_o(ale_o), .ce_n_o(ce_n_o), .we_n_o(we_n_o), .output_strobe_n_o(output_strobe_n_o),
	.write_protect_n_o(write_protect_n_o), .dq_oe_o(dq_oe_o));
`default_nettype wire

// ### bench/tb_top.sv
// Purpose: Self-checking bench for the NAND host over its register bus.
// Assumes: The memory model answers busy within ten microseconds.
// Notes:   Each scenario judges its own results.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	// ====
	// Signals
	logic        clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        en_i = 1'b1;
	logic [1:0]  avs_address_i = 2'h0;
	logic        avs_read_i = 1'b0;
	logic        avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [31:0] avs_readdata_o;
	logic        avs_waitrequest_o;
	logic        cle, ale, ce_n, we_n, re_n, wp_n, dq_oe, rb_n;
	logic [7:0]  dq_h;
	logic [7:0]  dq_m;
	logic [31:0] q;
	int          fails = 0;
	int          comparisons = 0;
	int          cyc = 0;
	always #50 clk_i = ~clk_i;
	always @(posedge clk_i) cyc <= cyc + 1;
	nand_host dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(en_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .cle_o(cle),
		.ale_o(ale), .ce_n_o(ce_n), .we_n_o(we_n), .output_strobe_n_o(re_n),
		.write_protect_n_o(wp_n), .dq_o(dq_h), .dq_oe_o(dq_oe), .dq_i(dq_m), .ready_busy_n_i(rb_n));
	nand_mem_model #(.BUSY_NS(10000)) nand_u (.cle_i(cle), .ale_i(ale), .ce_n_i(ce_n),
		.we_n_i(we_n), .re_n_i(re_n), .wp_n_i(wp_n), .dq_i(dq_h), .dq_o(dq_m), .rb_n_o(rb_n));
	// ====
	// Bus and compare tasks
	task automatic stop_test();
		if (fails == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		comparisons++;
		if (seen !== want) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic bus(input logic wr, input logic [1:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= wr;
		avs_read_i <= !wr;
		do begin
			@(posedge clk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 2000);
		q = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		if (n >= 2000) begin
			fails++;
			stop_test();
		end
	endtask
	task automatic rd(input logic [1:0] a, input logic [31:0] m, input logic [31:0] w);
		bus(1'b0, a, 32'h0);
		check(q & m, w);
	endtask
	task automatic op(input logic [2:0] k, input logic [7:0] b);
		int n;
		n = 0;
		bus(1'b1, nand_host_pkg::REG_OP, {21'h0, k, b});
		do begin
			bus(1'b0, nand_host_pkg::REG_STATUS, 32'h0);
			n++;
		end while (q[nand_host_pkg::ST_BUSY] !== 1'b0 && n < 300);
		if (n >= 300) begin
			fails++;
			stop_test();
		end
	endtask
	task automatic cmd(input logic [7:0] b); op(nand_host_pkg::KIND_CMD, b); endtask
	task automatic adr(input logic [7:0] b); op(nand_host_pkg::KIND_ADDR, b); endtask
	task automatic din(input logic [7:0] b); op(nand_host_pkg::KIND_DIN, b); endtask
	task automatic dout(input logic [7:0] want);
		op(nand_host_pkg::KIND_DOUT, 8'h00);
		rd(nand_host_pkg::REG_DATA, 32'hff, {24'h0, want});
	endtask
	task automatic addr5(input logic [11:0] col, input logic [7:0] row);
		adr(col[7:0]);
		adr({4'h0, col[11:8]});
		adr(row);
		adr(8'h00);
		adr(8'h00);
	endtask
	task automatic rnd(input logic [11:0] col);
		cmd(nand_host_pkg::CMD_RND_OUT);
		adr(col[7:0]);
		adr({4'h0, col[11:8]});
		cmd(nand_host_pkg::CMD_RND_GO);
	endtask
	// ====
	// Scenarios
	task automatic t_read();
		rd(nand_host_pkg::REG_STATUS, 32'h2, 32'h0);
		check(wp_n, 1'b0);
		addr5(12'h010, 8'h05);
		check(cyc >= 1004, 1'b1);
		cmd(nand_host_pkg::CMD_READ_GO);
		op(nand_host_pkg::KIND_WAIT, 8'h00);
		rd(nand_host_pkg::REG_STATUS, 32'h2e, 32'h6);
		dout(8'h15);
		dout(8'h14);
		rnd(12'h140);
		dout(8'h45);
		rnd(12'h83f);
		dout(8'h3a);
	endtask
	task automatic t_prog();
		bus(1'b1, nand_host_pkg::REG_CTRL, 32'h1);
		rd(nand_host_pkg::REG_CTRL, 32'h1, 32'h1);
		check(wp_n, 1'b1);
		rd(nand_host_pkg::REG_STATUS, 32'h10, 32'h10);
		cmd(nand_host_pkg::CMD_PROG);
		addr5(12'h000, 8'h07);
		din(8'ha5);
		din(8'h3c);
		cmd(nand_host_pkg::CMD_RND_IN);
		adr(8'h00);
		adr(8'h01);
		din(8'h5a);
		cmd(nand_host_pkg::CMD_CONFIRM);
		rd(nand_host_pkg::REG_STATUS, 32'hc, 32'h0);
		cmd(nand_host_pkg::CMD_READ);
		rd(nand_host_pkg::REG_STATUS, 32'h8, 32'h8);
		bus(1'b1, nand_host_pkg::REG_STATUS, 32'h8);
		op(nand_host_pkg::KIND_WAIT, 8'h00);
		check(nand_u.buf_q[0], 8'ha5);
		check(nand_u.buf_q[1], 8'h3c);
		check(nand_u.buf_q[256], 8'h5a);
		cmd(nand_host_pkg::CMD_STATUS);
		dout(8'hc0);
		dout(8'hc0);
	endtask
	task automatic t_refuse();
		cmd(nand_host_pkg::CMD_CONFIRM);
		rd(nand_host_pkg::REG_STATUS, 32'h8, 32'h8);
		bus(1'b1, nand_host_pkg::REG_STATUS, 32'h8);
		rd(nand_host_pkg::REG_STATUS, 32'h8, 32'h0);
		bus(1'b1, nand_host_pkg::REG_CTRL, 32'h0);
		rd(nand_host_pkg::REG_CTRL, 32'h3, 32'h0);
		check(wp_n, 1'b0);
		rd(nand_host_pkg::REG_STATUS, 32'h10, 32'h0);
	endtask
	task automatic t_order();
		cmd(nand_host_pkg::CMD_PROG);
		addr5(12'h000, 8'h05);
		din(8'h11);
		cmd(nand_host_pkg::CMD_CONFIRM);
		rd(nand_host_pkg::REG_STATUS, 32'h8, 32'h8);
		bus(1'b1, nand_host_pkg::REG_STATUS, 32'h8);
		cmd(nand_host_pkg::CMD_PROG);
		addr5(12'h000, 8'h08);
		din(8'h22);
		cmd(nand_host_pkg::CMD_DUMMY);
		rd(nand_host_pkg::REG_STATUS, 32'h8, 32'h0);
		cmd(nand_host_pkg::CMD_READ);
		rd(nand_host_pkg::REG_STATUS, 32'h8, 32'h8);
		bus(1'b1, nand_host_pkg::REG_STATUS, 32'h8);
		cmd(nand_host_pkg::CMD_PLANE2);
		rd(nand_host_pkg::REG_STATUS, 32'h8, 32'h0);
	endtask
	task automatic t_hold();
		en_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		check(avs_waitrequest_o, 1'b1);
		en_i <= 1'b1;
		rd(nand_host_pkg::REG_STATUS, 32'h1, 32'h0);
	endtask
	initial begin
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		t_read();
		t_prog();
		t_order();
		t_refuse();
		t_hold();
		stop_test();
	end
endmodule
`default_nettype wire
